/* File: verilog/dtr_pkg.sv */
// Constants, types and layouts for the dual temperature readout block.
// Assumes a shared ADC and an outside serial bus slave that reads registers.
//
// Behaviour
// R1: Local result is a 10-bit two's complement value.
// R2: Local result LSB weighs a quarter degree Celsius.
// R3: Remote result is an 11-bit two's complement value.
// R4: Remote result LSB weighs an eighth degree Celsius.
// R5: Integer part of both channels is an 8-bit two's complement byte.
// R6: Remote fraction is a 3-bit unsigned code in eighths of a degree.
// R7: Local fraction is a 2-bit unsigned code in quarters of a degree.
// R8: Fraction bits of both channels sit together in register 0x06.
// R9: Remote result is the average of 16 consecutive measurement cycles.
// R10: One remote measurement takes a nominal 9.6 ms.
// R11: Remote range spans -127 to +127.75 degrees in eighth steps.
// R12: Remote bias switches between base current and a multiple of it.
// R13: Remote short or open at power-up sets a sticky uncleared error flag.
// R14: Integer and fraction of a channel update together, never mixed.
package dtr_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int MEAS_TIME_NS = 9_600_000;
    localparam int MEAS_CYCLES = MEAS_TIME_NS / CLK_PERIOD_NS;
    localparam int SUB_COUNT = 16;
    localparam int TMR_W = 18;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_STATUS1 = 8'h02;
    localparam logic [7:0] ADDR_EXT_FRAC = 8'h06;
    localparam logic [7:0] ADDR_LOCAL_INT = 8'h0A;
    localparam logic [7:0] ADDR_REMOTE_INT = 8'h0B;
    localparam int STAT_DIODE_ERR_BIT = 5;
    localparam int EXT_REMOTE_LSB = 5;
    localparam int EXT_LOCAL_LSB = 0;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ****************************************************************
    // Data formats
    // ****************************************************************
    localparam int LOCAL_W = 10;
    localparam int REMOTE_W = 11;
    localparam int LOCAL_FRAC_W = 2;
    localparam int REMOTE_FRAC_W = 3;
    localparam int ACC_W = 15;
    localparam logic signed [REMOTE_W-1:0] REMOTE_MIN = 11'sh408;
    localparam logic signed [REMOTE_W-1:0] REMOTE_MAX = 11'sh3FE;

    typedef enum logic [1:0] {
        DTR_ST_SUB = 2'b00,
        DTR_ST_RCONV = 2'b01,
        DTR_ST_RAVG = 2'b10,
        DTR_ST_LCONV = 2'b11
    } dtr_state_e;

    typedef struct packed {
        logic start;
        logic remote;
    } dtr_adc_req_s;

    typedef struct packed {
        logic done;
        logic signed [REMOTE_W-1:0] data;
    } dtr_adc_rsp_s;

endpackage : dtr_pkg

/* File: verilog/dtr_avg.sv */
// Sixteen-sample averager for the remote channel.
// Assumes one add pulse per sample and a last flag on the final one.
`timescale 1ns/1ps

module dtr_avg
    import dtr_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic add_en,
    input wire logic last,
    input wire logic signed [REMOTE_W-1:0] sample,
    output logic signed [REMOTE_W-1:0] avg,
    output logic avg_valid
);

    typedef struct packed {
        logic signed [ACC_W-1:0] sum;
        logic signed [REMOTE_W-1:0] avg;
        logic valid;
    } dtr_avg_s;

    dtr_avg_s st_r;
    dtr_avg_s st_nxt;
    logic signed [ACC_W-1:0] total;
    logic signed [ACC_W-1:0] mean;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        total = st_r.sum + ACC_W'(sample);
        mean = total >>> 4; // R9
        if (add_en)
        begin
            st_nxt.sum = total;
            if (last)
            begin
                st_nxt.sum = '0;
                st_nxt.valid = 1'b1;
                // Clamp keeps a noisy average inside the reportable span
                if (mean < ACC_W'(REMOTE_MIN))
                    st_nxt.avg = REMOTE_MIN; // R11
                else if (mean > ACC_W'(REMOTE_MAX))
                    st_nxt.avg = REMOTE_MAX; // R11
                else
                    st_nxt.avg = mean[REMOTE_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign avg = st_r.avg;
    assign avg_valid = st_r.valid;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_avg_range: assert property ( // R11
        avg_valid |-> (avg >= REMOTE_MIN && avg <= REMOTE_MAX))
        else $error("average outside range");
    a_avg_clear: assert property ( // R9
        add_en && last |=> st_r.sum == '0 && avg_valid)
        else $error("accumulator not restarted");

endmodule : dtr_avg

/* File: verilog/dtr_readout.sv */
// Readout sequencer, formatter and register file for both channels.
// Assumes a shared ADC answering each start with one done pulse, and an
// outside bus slave presenting a register address.
`timescale 1ns/1ps

module dtr_readout
    import dtr_pkg::*;
#(
    parameter int MEAS_CYC = MEAS_CYCLES
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input dtr_adc_rsp_s adc_rsp,
    input wire logic diode_fault,
    input wire logic [7:0] reg_addr,
    output dtr_adc_req_s adc_req,
    output logic bias_high,
    output logic [7:0] reg_rd_data,
    output logic diode_error
);

    // ****************************************************************
    // Sub-cycle timing
    // ****************************************************************
    // Measurement time is shared evenly between the 16 sub-cycles
    localparam int SUB_CYC = MEAS_CYC / SUB_COUNT;
    localparam logic [TMR_W-1:0] SUB_LAST = TMR_W'(SUB_CYC - 1);
    localparam logic [TMR_W-1:0] HALF = TMR_W'(SUB_CYC / 2);

    typedef struct packed {
        dtr_state_e st;
        logic [TMR_W-1:0] tmr;
        logic [3:0] idx;
        logic bias_hi;
        logic adc_start;
        logic adc_remote;
        logic [7:0] l_int;
        logic [LOCAL_FRAC_W-1:0] l_frac;
        logic [7:0] r_int;
        logic [REMOTE_FRAC_W-1:0] r_frac;
        logic diode_err;
        logic powerup;
        logic [7:0] rd_data;
    } dtr_state_s;

    dtr_state_s st_r;
    dtr_state_s st_nxt;
    logic acc_add;
    logic acc_last;
    logic signed [REMOTE_W-1:0] avg;
    logic avg_valid;
    logic [7:0] ext_frac;

    dtr_avg dtr_avg_inst (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .add_en(acc_add),
        .last(acc_last),
        .sample(adc_rsp.data),
        .avg(avg),
        .avg_valid(avg_valid)
    );

    always_comb
    begin
        ext_frac = '0;
        ext_frac[EXT_REMOTE_LSB +: REMOTE_FRAC_W] = st_r.r_frac; // R8
        ext_frac[EXT_LOCAL_LSB +: LOCAL_FRAC_W] = st_r.l_frac; // R8
    end

    // ****************************************************************
    // Sequencer and formatter
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.adc_start = 1'b0;
        acc_add = 1'b0;
        acc_last = 1'b0;
        unique case (st_r.st)
            DTR_ST_SUB:
            begin
                // Base current first half, multiplied current second half
                st_nxt.tmr = st_r.tmr + TMR_W'(1);
                st_nxt.bias_hi = (st_nxt.tmr >= HALF); // R12
                if (st_r.tmr == SUB_LAST) // R10
                begin
                    st_nxt.tmr = '0;
                    st_nxt.bias_hi = 1'b0;
                    st_nxt.adc_start = 1'b1;
                    st_nxt.adc_remote = 1'b1;
                    st_nxt.st = DTR_ST_RCONV;
                end
            end
            DTR_ST_RCONV:
            begin
                if (adc_rsp.done)
                begin
                    acc_add = 1'b1; // R9
                    acc_last = (st_r.idx == 4'hF);
                    st_nxt.idx = st_r.idx + 4'h1;
                    st_nxt.st = acc_last ? DTR_ST_RAVG : DTR_ST_SUB;
                end
                // A fault seen during the first measurement is latched
                if (st_r.powerup && diode_fault)
                    st_nxt.diode_err = 1'b1; // R13
            end
            DTR_ST_RAVG:
            begin
                if (avg_valid)
                begin
                    // Integer and fraction committed in one edge
                    st_nxt.r_int = avg[REMOTE_W-1:REMOTE_FRAC_W]; // R3 R4 R5
                    st_nxt.r_frac = avg[REMOTE_FRAC_W-1:0]; // R6 R14
                    st_nxt.powerup = 1'b0;
                    st_nxt.adc_start = 1'b1;
                    st_nxt.adc_remote = 1'b0;
                    st_nxt.st = DTR_ST_LCONV;
                end
            end
            DTR_ST_LCONV:
            begin
                if (adc_rsp.done)
                begin
                    st_nxt.l_int =
                        adc_rsp.data[LOCAL_W-1:LOCAL_FRAC_W]; // R1 R2 R5
                    st_nxt.l_frac =
                        adc_rsp.data[LOCAL_FRAC_W-1:0]; // R7 R14
                    st_nxt.st = DTR_ST_SUB;
                end
            end
        endcase

        // Read data is registered: one cycle from address to data
        unique case (reg_addr)
            ADDR_STATUS1:
            begin
                st_nxt.rd_data = '0;
                st_nxt.rd_data[STAT_DIODE_ERR_BIT] = st_r.diode_err; // R13
            end
            ADDR_EXT_FRAC: st_nxt.rd_data = ext_frac; // R8
            ADDR_LOCAL_INT: st_nxt.rd_data = st_r.l_int; // R5
            ADDR_REMOTE_INT: st_nxt.rd_data = st_r.r_int; // R5
            default: st_nxt.rd_data = '0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.st <= DTR_ST_SUB;
            st_r.powerup <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign adc_req.start = st_r.adc_start;
    assign adc_req.remote = st_r.adc_remote;
    assign bias_high = st_r.bias_hi;
    assign reg_rd_data = st_r.rd_data;
    assign diode_error = st_r.diode_err;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_diode_sticky: assert property ( // R13
        st_r.diode_err |=> st_r.diode_err)
        else $error("diode error flag cleared");
    a_diode_late: assert property ( // R13
        !st_r.powerup && !st_r.diode_err |=> !st_r.diode_err)
        else $error("diode error set after power-up");
    a_remote_commit: assert property ( // R14
        st_r.st == DTR_ST_RAVG && avg_valid |=>
        st_r.r_int == $past(avg[10:3]) && st_r.r_frac == $past(avg[2:0]))
        else $error("remote parts not committed together");
    a_local_commit: assert property ( // R14
        st_r.st == DTR_ST_LCONV && adc_rsp.done |=>
        st_r.l_int == $past(adc_rsp.data[9:2]) &&
        st_r.l_frac == $past(adc_rsp.data[1:0]))
        else $error("local parts not committed together");
    a_bias_phase: assert property ( // R12
        st_r.st == DTR_ST_SUB && st_r.tmr != '0 |->
        st_r.bias_hi == (st_r.tmr >= HALF))
        else $error("bias phase wrong");
    a_sub_start: assert property ( // R10
        st_r.st == DTR_ST_SUB && st_r.tmr == SUB_LAST |=>
        adc_req.start && adc_req.remote && st_r.st == DTR_ST_RCONV)
        else $error("sub-cycle conversion not started");
    a_sixteen_cycles: assert property ( // R9
        st_r.st == DTR_ST_RCONV && adc_rsp.done && st_r.idx == 4'hF |=>
        st_r.st == DTR_ST_RAVG && avg_valid)
        else $error("average not produced after 16");
    a_ext_read: assert property ( // R8
        reg_addr == ADDR_EXT_FRAC |=>
        reg_rd_data == {st_r.r_frac, 3'h0, st_r.l_frac} ||
        $changed(st_r.l_frac) || $changed(st_r.r_frac))
        else $error("extended register wrong");
    a_status_read: assert property ( // R13
        reg_addr == ADDR_STATUS1 |=> reg_rd_data[5] == $past(st_r.diode_err))
        else $error("status bit wrong");

    c_remote_done: cover property (st_r.st == DTR_ST_RAVG && avg_valid);
    c_local_done: cover property (st_r.st == DTR_ST_LCONV && adc_rsp.done);
    c_diode_err: cover property ($rose(st_r.diode_err));
    c_ext_read: cover property (reg_addr == ADDR_EXT_FRAC);

endmodule : dtr_readout

/* File: dv/test_dtr_readout.sv */
// Self-checking bench for the readout block, ADC answered by hand.
// Assumes the block alone, with a shortened measurement period.
`timescale 1ns/1ps

module test_dtr_readout;
    import dtr_pkg::*;

    localparam int HALF = 10;
    localparam int MEAS = 320;
    localparam int SUB_LEN = MEAS / SUB_COUNT;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    dtr_adc_rsp_s adc_rsp = '0;
    logic diode_fault = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    dtr_adc_req_s adc_req;
    logic bias_high;
    logic [7:0] reg_rd_data;
    logic diode_error;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    // Short period keeps a full run just over two thousand cycles
    dtr_readout #(.MEAS_CYC(MEAS)) dtr_readout_inst (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .adc_rsp(adc_rsp),
        .diode_fault(diode_fault),
        .reg_addr(reg_addr),
        .adc_req(adc_req),
        .bias_high(bias_high),
        .reg_rd_data(reg_rd_data),
        .diode_error(diode_error)
    );

    always #25 mclk = ~mclk;

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            wrap_up();
        end
    end

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic wrap_up();
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Data is registered one edge after the address edge
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge mclk);
        reg_addr = addr;
        @(negedge mclk);
        check(reg_rd_data, exp);
    endtask : rd_chk

    task automatic wait_start(input logic remote, output int hi,
        output int len);
        int n;
        hi = 0;
        n = 0;
        @(negedge mclk);
        while (adc_req.start !== 1'b1 && n < 200)
        begin
            hi += (bias_high === 1'b1);
            n++;
            @(negedge mclk);
        end
        len = n;
        check({7'h00, adc_req.remote}, {7'h00, remote});
        check({7'h00, bias_high}, 8'h00);
    endtask : wait_start

    // Data toggles while done is low so stale values never match
    task automatic serve(input logic [10:0] d);
        @(negedge mclk);
        adc_rsp.done = 1'b1;
        adc_rsp.data = d;
        @(negedge mclk);
        adc_rsp.done = 1'b0;
        adc_rsp.data = ~d;
    endtask : serve

    task automatic measure(input int base, input int step,
        input logic [9:0] loc, input logic flt);
        int sum;
        int avg;
        int hi;
        int len;
        logic [10:0] a;
        sum = 0;
        diode_fault = flt;
        for (int i = 0; i < 16; i++)
        begin
            wait_start(1'b1, hi, len);
            check(hi[7:0], 8'(HALF));
            // Sub-cycles after a done run a full period from timer one
            if (i > 0)
            begin
                check(len[7:0], 8'(SUB_LEN - 1));
            end
            serve(11'(base + i * step));
            sum += base + i * step;
        end
        diode_fault = 1'b0;
        wait_start(1'b0, hi, len);
        serve({1'b0, loc});
        avg = sum >>> 4;
        avg = avg < -1016 ? -1016 : (avg > 1022 ? 1022 : avg);
        a = avg[10:0];
        repeat (2) @(negedge mclk);
        rd_chk(ADDR_REMOTE_INT, a[10:3]);
        rd_chk(ADDR_EXT_FRAC, {a[2:0], 3'b000, loc[1:0]});
        rd_chk(ADDR_LOCAL_INT, loc[9:2]);
    endtask : measure

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        rd_chk(ADDR_STATUS1, 8'h00);
        rd_chk(8'h55, 8'h00);
        measure(100, 1, 10'h064, 1'b1);
        check({7'h00, diode_error}, 8'h01);
        measure(-1, 0, 10'h3FF, 1'b0);
        measure(-1024, 0, 10'h200, 1'b0);
        measure(1023, 0, 10'h001, 1'b0);
        rd_chk(ADDR_STATUS1, 8'h20);
        check({7'h00, diode_error}, 8'h01);
        // Only a reset may drop the sticky flag
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        rd_chk(ADDR_STATUS1, 8'h00);
        check({7'h00, diode_error}, 8'h00);
        measure(9, 0, 10'h005, 1'b0);
        // Fault after the power-up window must not raise the flag
        measure(9, 0, 10'h005, 1'b1);
        check({7'h00, diode_error}, 8'h00);
        rd_chk(ADDR_STATUS1, 8'h00);
        wrap_up();
    end

endmodule : test_dtr_readout
